// *** design/psm_ctrl.sv ***
`timescale 1ns/1ps
`include "psm_defines.svh"
module psm_ctrl #(
	parameter bit HAS_WAKE_SEL = 1'b1
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic IRQ_PENDING,
	input wire logic EXT_INT0_WAKE_PIN,
	input wire logic SERIAL_RX_WAKE_PIN,
	input wire logic HW_POWERDOWN_PIN_N,
	output logic CPU_CLK_EN,
	output logic PERIPH_CLK_EN,
	output logic OSC_EN,
	output logic RAM_RETAIN,
	output logic [2:0] MODE
);
	// pin synchronisers: first stage read only by the second
	logic int0_s1_q;
	logic int0_s2_q;
	logic int0_s3_q;
	logic rxd_s1_q;
	logic rxd_s2_q;
	logic rxd_s3_q;
	logic hw_powerdown_pin_n_s1_q;
	logic hw_powerdown_pin_n_s2_q;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			int0_s1_q <= 1'b1;
			int0_s2_q <= 1'b1;
			int0_s3_q <= 1'b1;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			rxd_s3_q <= 1'b1;
			hw_powerdown_pin_n_s1_q <= 1'b1;
			hw_powerdown_pin_n_s2_q <= 1'b1;
		end else begin
			int0_s1_q <= EXT_INT0_WAKE_PIN;
			int0_s2_q <= int0_s1_q;
			int0_s3_q <= int0_s2_q;
			rxd_s1_q <= SERIAL_RX_WAKE_PIN;
			rxd_s2_q <= rxd_s1_q;
			rxd_s3_q <= rxd_s2_q;
			hw_powerdown_pin_n_s1_q <= HW_POWERDOWN_PIN_N;
			hw_powerdown_pin_n_s2_q <= hw_powerdown_pin_n_s1_q;
		end
	end

	// register state
	logic slow_q;
	logic slow_d;
	logic wake_sel_q;
	logic wake_sel_d;
	logic [1:0] last_wake_q;
	logic [1:0] last_wake_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	psm_pkg::psm_state_t state_q;
	psm_pkg::psm_state_t state_d;
	logic [`PSM_OSC_CNT_W-1:0] osc_cnt_q;
	logic [`PSM_OSC_CNT_W-1:0] osc_cnt_d;

	// apb decode
	wire setup = PSEL && !PENABLE;
	wire access = PSEL && PENABLE;
	wire hit_ctrl = (PADDR == `PSM_ADDR_CTRL);
	wire hit_aux = (PADDR == `PSM_ADDR_AUX);
	wire hit_stat = (PADDR == `PSM_ADDR_STAT);
	wire mapped = hit_ctrl || hit_aux || hit_stat;
	wire wr_ctrl = access && PWRITE && hit_ctrl;
	wire wr_aux = access && PWRITE && hit_aux;

	// software requests are single-cycle strobes from a write to the control register
	wire idle_req = wr_ctrl && PWDATA[`PSM_CTRL_IDLE];
	wire pd_req = wr_ctrl && PWDATA[`PSM_CTRL_PDOWN];

	// selector only exists on some variants; the others hard-wire int0
	wire sel_rxd = HAS_WAKE_SEL && wake_sel_q;
	wire pin_now = sel_rxd ? rxd_s2_q : int0_s2_q;
	wire pin_prev = sel_rxd ? rxd_s3_q : int0_s3_q;
	// falling edge marks the start of the short low pulse
	wire wake_fall = pin_prev && !pin_now;
	wire hw_pd = !hw_powerdown_pin_n_s2_q;
	wire osc_done = (osc_cnt_q == '0);

	wire [31:0] stat_word = {22'h00_0000, last_wake_q, hw_pd, OSC_EN, wake_sel_q, slow_q,
		1'b0, state_q};
	wire [31:0] ctrl_word = {29'h0000_0000, slow_q, 2'h0};
	wire [31:0] aux_word = {27'h000_0000, wake_sel_q, 4'h0};

	assign prdata_d = !setup || PWRITE ? prdata_q :
		hit_ctrl ? ctrl_word :
		hit_aux ? aux_word :
		hit_stat ? stat_word : `PSM_RESET_WORD;
	assign slow_d = wr_ctrl ? PWDATA[`PSM_CTRL_SLOW] : slow_q;
	assign wake_sel_d = wr_aux ? PWDATA[`PSM_AUX_WAKE_SEL] : wake_sel_q;

	// mode sequencer; hardware power down outranks everything
	always_comb begin
		state_d = state_q;
		last_wake_d = last_wake_q;
		osc_cnt_d = osc_cnt_q;
		unique case (state_q)
			psm_pkg::PSM_RUN: begin
				if (hw_pd) begin
					state_d = psm_pkg::PSM_PD_HW;
				end else if (pd_req) begin
					state_d = psm_pkg::PSM_PD_SW;
				end else if (idle_req) begin
					state_d = psm_pkg::PSM_IDLE;
				end
			end
			psm_pkg::PSM_IDLE: begin
				if (hw_pd) begin
					state_d = psm_pkg::PSM_PD_HW;
				end else if (IRQ_PENDING) begin
					// nothing is reset on the way out, so execution resumes in place
					state_d = psm_pkg::PSM_RUN;
					last_wake_d = `PSM_WAKE_IRQ;
				end
			end
			psm_pkg::PSM_PD_SW: begin
				if (hw_pd) begin
					state_d = psm_pkg::PSM_PD_HW;
				end else if (wake_fall) begin
					state_d = psm_pkg::PSM_OSC_WAIT;
					osc_cnt_d = `PSM_OSC_CNT_W'(`PSM_OSC_START_CYC - 1);
					last_wake_d = `PSM_WAKE_PIN;
				end
			end
			psm_pkg::PSM_OSC_WAIT: begin
				if (hw_pd) begin
					state_d = psm_pkg::PSM_PD_HW;
				end else if (osc_done) begin
					state_d = psm_pkg::PSM_RUN;
				end else begin
					osc_cnt_d = osc_cnt_q - 1'b1;
				end
			end
			psm_pkg::PSM_PD_HW: begin
				if (!hw_pd) begin
					// oscillator needs its start-up time after a hardware stop too
					state_d = psm_pkg::PSM_OSC_WAIT;
					osc_cnt_d = `PSM_OSC_CNT_W'(`PSM_OSC_START_CYC - 1);
					last_wake_d = `PSM_WAKE_HW;
				end
			end
			default: begin
				state_d = psm_pkg::PSM_RUN;
			end
		endcase
	end

	// synchronous reset returns every mode bit to its reset value
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= psm_pkg::PSM_RUN;
			slow_q <= 1'b0;
			wake_sel_q <= 1'b0;
			last_wake_q <= `PSM_WAKE_NONE;
			osc_cnt_q <= '0;
			prdata_q <= `PSM_RESET_WORD;
		end else begin
			state_q <= state_d;
			slow_q <= slow_d;
			wake_sel_q <= wake_sel_d;
			last_wake_q <= last_wake_d;
			osc_cnt_q <= osc_cnt_d;
			prdata_q <= prdata_d;
		end
	end

	// clock enable generation
	logic tick;
	wire clocked = (state_q == psm_pkg::PSM_RUN) || (state_q == psm_pkg::PSM_IDLE);

	psm_clk_div u_div (
		.clk(CLK),
		.rst_n(RST_N),
		.run(clocked),
		.slow(slow_q),
		.tick(tick)
	);

	// core enable stops in idle, peripheral enable runs through it, both share one divider
	assign CPU_CLK_EN = tick && (state_q == psm_pkg::PSM_RUN);
	assign PERIPH_CLK_EN = tick;
	// oscillator off in both power down states, back on for restart wait
	assign OSC_EN = (state_q != psm_pkg::PSM_PD_SW) && (state_q != psm_pkg::PSM_PD_HW);
	// ram keeps its contents in both power down states; flagged for the supply switch
	assign RAM_RETAIN = !OSC_EN;
	assign MODE = state_q;

	// zero wait states; an unmapped address errors and reads zero
	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;
	assign PRDATA = prdata_q;

	// check-only counters; a divider or restart counter that wraps early shows as a mismatch
	logic [`PSM_DIV_W-1:0] slow_gap_q;
	logic [`PSM_OSC_CNT_W-1:0] osc_wait_q;

	always_ff @(posedge CLK) begin
		if (!RST_N || !clocked || !slow_q || PERIPH_CLK_EN) begin
			slow_gap_q <= '0;
		end else begin
			slow_gap_q <= slow_gap_q + 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N || state_q != psm_pkg::PSM_OSC_WAIT) begin
			osc_wait_q <= '0;
		end else begin
			osc_wait_q <= osc_wait_q + 1'b1;
		end
	end

	// checks
	a_idle_core_gated: assert property (@(posedge CLK) disable iff (!RST_N)
		state_q == psm_pkg::PSM_IDLE |-> !CPU_CLK_EN)
		else $error("core clock running in idle");

	a_idle_periph_runs: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_IDLE && !slow_q) |-> PERIPH_CLK_EN)
		else $error("peripheral clock stopped in idle");

	a_idle_entry_sw: assert property (@(posedge CLK) disable iff (!RST_N)
		($past(state_q) == psm_pkg::PSM_RUN && state_q == psm_pkg::PSM_IDLE)
		|-> $past(idle_req))
		else $error("idle entered without request");

	a_idle_irq_exit: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_IDLE && IRQ_PENDING && !hw_pd)
		|=> state_q == psm_pkg::PSM_RUN && last_wake_q == `PSM_WAKE_IRQ)
		else $error("idle not left on interrupt");

	a_pd_osc_off: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_PD_SW || state_q == psm_pkg::PSM_PD_HW)
		|-> !OSC_EN && !PERIPH_CLK_EN && !CPU_CLK_EN)
		else $error("clock running in power down");

	a_pd_pin_wake: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_PD_SW && !hw_pd && wake_fall)
		|=> state_q == psm_pkg::PSM_OSC_WAIT)
		else $error("wake pulse ignored");

	a_pd_stays: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_PD_SW && !hw_pd && !wake_fall)
		|=> state_q == psm_pkg::PSM_PD_SW)
		else $error("power down left without wake");

	a_hw_powerdown_pin_n_entry: assert property (@(posedge CLK) disable iff (!RST_N)
		(!HW_POWERDOWN_PIN_N [*3]) |=> state_q == psm_pkg::PSM_PD_HW)
		else $error("hardware power down not entered");

	a_slow_period: assert property (@(posedge CLK) disable iff (!RST_N)
		(slow_q && clocked)
		|-> PERIPH_CLK_EN == (slow_gap_q == `PSM_DIV_W'(`PSM_DIV_RATIO - 1)))
		else $error("slow-down pulse spacing wrong");

	a_slow_idle: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_IDLE && slow_q && PERIPH_CLK_EN && !IRQ_PENDING && !hw_pd)
		|=> !PERIPH_CLK_EN)
		else $error("idle with slow-down not divided");

	a_osc_restart: assert property (@(posedge CLK) disable iff (!RST_N)
		($past(state_q) == psm_pkg::PSM_PD_SW && state_q == psm_pkg::PSM_OSC_WAIT)
		|-> (!CPU_CLK_EN && OSC_EN) [*8] ##1 (!CPU_CLK_EN [*8]))
		else $error("core resumed before oscillator start");

	a_wake_sel_rxd: assert property (@(posedge CLK) disable iff (!RST_N)
		(wake_sel_q && HAS_WAKE_SEL && state_q == psm_pkg::PSM_PD_SW && !hw_pd
		&& rxd_s3_q && !rxd_s2_q) |=> state_q == psm_pkg::PSM_OSC_WAIT)
		else $error("serial receive wake not honoured");

	a_reset_state: assert property (@(posedge CLK)
		!RST_N |=> state_q == psm_pkg::PSM_RUN && !slow_q && !wake_sel_q)
		else $error("reset state not loaded");

	a_irq_keeps_slow: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_IDLE && IRQ_PENDING && !hw_pd)
		|=> slow_q == $past(slow_q) && wake_sel_q == $past(wake_sel_q))
		else $error("state lost on interrupt exit");

	a_osc_wait_len: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_OSC_WAIT && !hw_pd)
		|-> osc_done == (osc_wait_q == `PSM_OSC_CNT_W'(`PSM_OSC_START_CYC - 1)))
		else $error("oscillator wait length wrong");

	a_osc_wait_exit: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_OSC_WAIT && osc_done && !hw_pd)
		|=> state_q == psm_pkg::PSM_RUN)
		else $error("run not resumed after oscillator wait");

	a_pd_sw_entry: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_RUN && pd_req && !hw_pd)
		|=> state_q == psm_pkg::PSM_PD_SW)
		else $error("power down request ignored");

	a_idle_entry_req: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_RUN && idle_req && !pd_req && !hw_pd)
		|=> state_q == psm_pkg::PSM_IDLE)
		else $error("idle request ignored");

	a_idle_holds: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_IDLE && !IRQ_PENDING && !hw_pd)
		|=> state_q == psm_pkg::PSM_IDLE)
		else $error("idle left without interrupt");

	a_hw_powerdown_pin_n_any_state: assert property (@(posedge CLK) disable iff (!RST_N)
		(hw_pd && state_q != psm_pkg::PSM_PD_HW)
		|=> state_q == psm_pkg::PSM_PD_HW)
		else $error("hardware power down not taken");

	a_hw_powerdown_pin_n_release: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_PD_HW && !hw_pd)
		|=> state_q == psm_pkg::PSM_OSC_WAIT && last_wake_q == `PSM_WAKE_HW)
		else $error("hardware power down release wrong");

	a_ram_retain_pd: assert property (@(posedge CLK) disable iff (!RST_N)
		RAM_RETAIN == (state_q == psm_pkg::PSM_PD_SW || state_q == psm_pkg::PSM_PD_HW))
		else $error("ram retention flag wrong");

	a_run_same_rate: assert property (@(posedge CLK) disable iff (!RST_N)
		state_q == psm_pkg::PSM_RUN |-> CPU_CLK_EN == PERIPH_CLK_EN)
		else $error("core and peripheral rates differ");

	a_int0_wake: assert property (@(posedge CLK) disable iff (!RST_N)
		(!sel_rxd && state_q == psm_pkg::PSM_PD_SW && !hw_pd && int0_s3_q && !int0_s2_q)
		|=> state_q == psm_pkg::PSM_OSC_WAIT)
		else $error("int0 wake not honoured");

	a_wake_cause_pin: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == psm_pkg::PSM_PD_SW && !hw_pd && wake_fall)
		|=> last_wake_q == `PSM_WAKE_PIN)
		else $error("pin wake cause not recorded");
endmodule : psm_ctrl

// *** design/psm_defines.svh ***
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// register byte addresses
`define PSM_ADDR_CTRL 8'h00
`define PSM_ADDR_AUX 8'h04
`define PSM_ADDR_STAT 8'h08

// control register fields
`define PSM_CTRL_IDLE 0
`define PSM_CTRL_PDOWN 1
`define PSM_CTRL_SLOW 2

// auxiliary control register field
`define PSM_AUX_WAKE_SEL 4

// status register fields
`define PSM_STAT_STATE_LO 0
`define PSM_STAT_STATE_HI 2
`define PSM_STAT_SLOW 4
`define PSM_STAT_WAKE_SEL 5
`define PSM_STAT_OSC_ON 6
`define PSM_STAT_HW_POWERDOWN_PIN_N 7
`define PSM_STAT_LAST_WAKE_LO 8
`define PSM_STAT_LAST_WAKE_HI 9

// last wake cause codes
`define PSM_WAKE_NONE 2'h0
`define PSM_WAKE_IRQ 2'h1
`define PSM_WAKE_PIN 2'h2
`define PSM_WAKE_HW 2'h3

// slow-down divide ratio and counter width
`define PSM_DIV_RATIO 32
`define PSM_DIV_W 5

// oscillator restart time
`define PSM_CLK_PERIOD_NS 50
`define PSM_OSC_START_NS 2000
`define PSM_OSC_START_CYC ((`PSM_OSC_START_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)
`define PSM_OSC_CNT_W 8

`define PSM_RESET_WORD 32'h0000_0000
`endif

// *** design/psm_pkg.sv ***
package psm_pkg;
	// gray along run -> idle -> power down -> oscillator restart -> hardware power down
	typedef enum logic [2:0] {
		PSM_RUN = 3'h0,
		PSM_IDLE = 3'h1,
		PSM_PD_SW = 3'h3,
		PSM_OSC_WAIT = 3'h2,
		PSM_PD_HW = 3'h6
	} psm_state_t;
endpackage : psm_pkg

// *** design/psm_clk_div.sv ***
`timescale 1ns/1ps
`include "psm_defines.svh"
module psm_clk_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic slow,
	output logic tick
);
	logic [`PSM_DIV_W-1:0] cnt_q;
	logic [`PSM_DIV_W-1:0] cnt_d;
	logic wrap;

	assign wrap = (cnt_q == `PSM_DIV_W'(`PSM_DIV_RATIO - 1));
	assign cnt_d = (!run || !slow || wrap) ? '0 : cnt_q + 1'b1;
	// one enable pulse per 32 cycles while slowed, every cycle otherwise
	assign tick = run && (!slow || wrap);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : psm_clk_div

// *** sim/psm_pin_model.sv ***
`timescale 1ns/1ps
module psm_pin_model (
	input wire logic clk,
	input wire logic pulse,
	input wire logic on_rx,
	input wire logic irq,
	input wire logic hw_powerdown_pin_n,
	output logic int0_pin = 1'b1,
	output logic rx_pin = 1'b1,
	output logic irq_pending = 1'b0,
	output logic hw_powerdown_pin_n_pin_n = 1'b1
);
	// pins sit high between pulses, as with a pull-up
	always_ff @(posedge clk) begin
		int0_pin <= !(pulse && !on_rx);
		rx_pin <= !(pulse && on_rx);
		irq_pending <= irq;
		hw_powerdown_pin_n_pin_n <= !hw_powerdown_pin_n;
	end
endmodule : psm_pin_model

// *** sim/test_power_saving_mode_control.sv ***
`timescale 1ns/1ps
module test_power_saving_mode_control;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, rd, prdata, d;
	logic pulse = 0, on_rx = 0, irq = 0, hw_powerdown_pin_n = 0, err;
	logic int0, rx, irqp, hwn, prdy, perr, cpu_en, per_en, osc, ram;
	logic [2:0] mode, mode1;
	int num_errors = 0, samples_checked = 0, seed = 57, n, cc, cp;
	always #25 clk = ~clk;
	psm_pin_model psm_pin_model_inst (.clk(clk), .pulse(pulse), .on_rx(on_rx), .irq(irq),
		.hw_powerdown_pin_n(hw_powerdown_pin_n), .int0_pin(int0), .rx_pin(rx), .irq_pending(irqp), .hw_powerdown_pin_n_pin_n(hwn));
	psm_ctrl psm_ctrl_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy),
		.PSLVERR(perr), .IRQ_PENDING(irqp), .EXT_INT0_WAKE_PIN(int0), .SERIAL_RX_WAKE_PIN(rx),
		.HW_POWERDOWN_PIN_N(hwn), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .OSC_EN(osc),
		.RAM_RETAIN(ram), .MODE(mode));
	// variant without selector, sharing every input
	psm_ctrl #(.HAS_WAKE_SEL(1'b0)) psm_ctrl_fixed_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
		.PREADY(), .PSLVERR(), .IRQ_PENDING(irqp), .EXT_INT0_WAKE_PIN(int0),
		.SERIAL_RX_WAKE_PIN(rx), .HW_POWERDOWN_PIN_N(hwn), .CPU_CLK_EN(), .PERIPH_CLK_EN(),
		.OSC_EN(), .RAM_RETAIN(), .MODE(mode1));
	// status model: mode, slow, wake select, oscillator, last wake cause
	function automatic logic [31:0] stat(int m, int sl, int ws, int os, int wk);
		return 32'(m) | 32'(sl) << 4 | 32'(ws) << 5 | 32'(os) << 6 | 32'(wk) << 8;
	endfunction : stat
	task test_done;
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		rd = prdata;
		err = perr;
		psel <= 0;
		penable <= 0;
		if (n >= 50) begin
			num_errors++;
			test_done();
		end
	endtask : apb
	// sampled on falling edges, away from the design's updates
	task wait_mode(input int which, input logic [2:0] m);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (((which ? mode1 : mode) !== m) && n < 200);
		if (n >= 200) begin
			num_errors++;
			test_done();
		end
	endtask : wait_mode
	task count_en;
		cc = 0;
		cp = 0;
		repeat (64) begin
			@(negedge clk);
			cc += int'(cpu_en);
			cp += int'(per_en);
		end
	endtask : count_en
	task pin_pulse(input logic r);
		@(posedge clk);
		on_rx <= r;
		pulse <= 1;
		repeat (4) @(posedge clk);
		pulse <= 0;
		repeat (14) @(negedge clk);
	endtask : pin_pulse
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		apb(0, 8'h08, 0);
		check(rd & 32'h0000_037f, stat(0, 0, 0, 1, 0));
		apb(0, 8'h0c, 0);
		check({err, rd}, 33'h1_0000_0000);
		d = $random(seed);
		apb(1, 8'h04, d);
		apb(1, 8'h00, 32'h0000_0001);
		wait_mode(0, 3'h1);
		check({cpu_en, per_en}, 2'b01);
		repeat (1 + $unsigned($random(seed)) % 8) @(posedge clk);
		irq <= 1;
		wait_mode(0, 3'h0);
		@(posedge clk);
		irq <= 0;
		apb(0, 8'h04, 0);
		check(rd, d & 32'h0000_0010);
		apb(1, 8'h00, 32'h0000_0004);
		count_en();
		check({cc, cp}, {32'd2, 32'd2});
		apb(1, 8'h00, 32'h0000_0005);
		wait_mode(0, 3'h1);
		count_en();
		check({cc, cp}, {32'd0, 32'd2});
		@(posedge clk);
		irq <= 1;
		wait_mode(0, 3'h0);
		@(posedge clk);
		irq <= 0;
		apb(1, 8'h00, 0);
		for (int s = 0; s < 2; s++) begin
			apb(1, 8'h04, 32'(s) << 4);
			apb(1, 8'h00, 32'h0000_0002);
			wait_mode(0, 3'h3);
			check({osc, ram, cpu_en, per_en}, 4'b0100);
			pin_pulse(s == 0);
			check(mode, 3'h3);
			check(mode1, s ? 3'h2 : 3'h3);
			pin_pulse(s == 1);
			wait_mode(0, 3'h2);
			check({osc, cpu_en}, 2'b10);
			wait_mode(0, 3'h0);
			wait_mode(1, 3'h0);
			apb(0, 8'h08, 0);
			check(rd & 32'h0000_037f, stat(0, 0, s, 1, 2));
		end
		@(posedge clk);
		hw_powerdown_pin_n <= 1;
		wait_mode(0, 3'h6);
		check(osc, 1'b0);
		apb(0, 8'h08, 0);
		check(rd & 32'h0000_03ff, stat(6, 0, 1, 0, 2) | 32'h0000_0080);
		@(posedge clk);
		hw_powerdown_pin_n <= 0;
		wait_mode(0, 3'h0);
		apb(0, 8'h08, 0);
		check(rd & 32'h0000_037f, stat(0, 0, 1, 1, 3));
		apb(1, 8'h00, 32'h0000_0005);
		wait_mode(0, 3'h1);
		@(posedge clk);
		rst_n <= 0;
		repeat (3) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(negedge clk);
		check({mode, cpu_en, per_en}, 5'b000_11);
		test_done();
	end
endmodule : test_power_saving_mode_control
